/* rtl/reset_wakeup_map.svh */
// register offsets, field positions, reset values and timing counts of the reset/wake block
`ifndef RESET_WAKEUP_MAP_SVH
`define RESET_WAKEUP_MAP_SVH

`define IDX_INDIRECT_DATA     8'h00
`define IDX_TIMER_COUNT       8'h01
`define IDX_PC_LOW            8'h02
`define IDX_STATUS            8'h03
`define IDX_INDIRECT_POINTER  8'h04
`define IDX_PORT_A            8'h05
`define IDX_PORT_B            8'h06
`define IDX_PC_HIGH_LATCH     8'h0a
`define IDX_INT_CONTROL       8'h0b
`define IDX_PERIPH_FLAGS      8'h0c
`define IDX_COMPARATOR        8'h1f
`define IDX_TIMER_OPTIONS     8'h81
`define IDX_PORT_A_DIR        8'h85
`define IDX_PORT_B_DIR        8'h86
`define IDX_PERIPH_ENABLES    8'h8c
`define IDX_POWER_FLAGS       8'h8e
`define IDX_VREF_CONTROL      8'h9f
`define IDX_ACCUMULATOR       8'ha0
`define IDX_CORE_CONTROL      8'ha1
`define IDX_EVENT_STATUS      8'ha2
`define IDX_EVENT_MASK        8'ha3

`define MASK_PORT_A           8'h1f
`define MASK_PC_HIGH_LATCH    8'h1f
`define MASK_COMPARATOR_WR    8'h0f
`define MASK_PERIPH           8'h40
`define MASK_POWER_FLAGS      8'h03
`define MASK_VREF             8'hef
`define MASK_EVENTS           8'h3f

`define RST_STATUS_POR        8'h18
`define RST_OPTIONS           8'hff
`define RST_PORT_A_DIR        8'h1f
`define RST_PORT_B_DIR        8'hff
`define RST_ZERO              8'h00
`define PINS_IDLE             8'h04
`define IRQ_VECTOR            13'h0004

`define BIT_TIMEOUT           4
`define BIT_POWERDOWN         3
`define BIT_GLOBAL_IRQ_ENABLE 7
`define BIT_PERIPH_COMP       6
`define BIT_FLAG_BROWNOUT     0

`define CLK_MHZ               25
`define WDT_PERIOD_US         18000
`define WDT_CYCLES            (`WDT_PERIOD_US * `CLK_MHZ)

`endif

/* rtl/reset_wakeup_pkg.sv */
// types shared by the reset/wake register block
package reset_wakeup_pkg;

    typedef enum logic [1:0] {
        ST_RUN    = 2'b00,
        ST_ASLEEP = 2'b01,
        ST_WAKE   = 2'b11,
        ST_VECTOR = 2'b10
    } core_state_t;

    typedef struct packed {
        logic       enable;
        logic       pin_output_enable;
        logic       range_select;
        logic       unused;
        logic [3:0] level;
    } vref_ctrl_t;

    typedef struct packed {
        logic comparator_two_result;
        logic comparator_one_result;
        logic comparator_change;
        logic port_change;
        logic int_pin;
        logic external_reset_pin_n;
        logic brownout_detect;
        logic power_fail;
    } pin_bundle_t;

endpackage

/* rtl/reset_wakeup_register_init.sv */
// reset and wake-up cause handling with the core's special registers behind apb
`timescale 1ns/1ps
`include "reset_wakeup_map.svh"

module reset_wakeup_register_init
    import reset_wakeup_pkg::*;
#(
    parameter int unsigned WDT_CYCLES = `WDT_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [9:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire pin_bundle_t pins,
    output logic             irq,
    output vref_ctrl_t       vref_out,
    output logic             core_asleep
);

    // refuse a watchdog period too short to count
    if (WDT_CYCLES < 2) begin : g_bad_wdt
        $error("WDT_CYCLES must be at least 2");
    end

    // decoded index is mapped when one of the registers sits there
    function automatic logic is_mapped(input logic [7:0] idx);
        case (idx)
            `IDX_INDIRECT_DATA, `IDX_TIMER_COUNT, `IDX_PC_LOW, `IDX_STATUS,
            `IDX_INDIRECT_POINTER, `IDX_PORT_A, `IDX_PORT_B, `IDX_PC_HIGH_LATCH,
            `IDX_INT_CONTROL, `IDX_PERIPH_FLAGS, `IDX_COMPARATOR,
            `IDX_TIMER_OPTIONS, `IDX_PORT_A_DIR, `IDX_PORT_B_DIR,
            `IDX_PERIPH_ENABLES, `IDX_POWER_FLAGS, `IDX_VREF_CONTROL,
            `IDX_ACCUMULATOR, `IDX_CORE_CONTROL, `IDX_EVENT_STATUS,
            `IDX_EVENT_MASK: is_mapped = 1'b1;
            default:         is_mapped = 1'b0;
        endcase
    endfunction

    // pin synchronisers: the first stage is read only by the second
    localparam int unsigned PIN_W = $bits(pin_bundle_t);
    logic [PIN_W-1:0] sync_a;
    logic [PIN_W-1:0] sync_b;
    logic [PIN_W-1:0] sync_prev;
    // reset to idle levels, so that leaving reset shows no false pin edge
    localparam logic [PIN_W-1:0] PIN_IDLE = `PINS_IDLE;
    genvar gi;
    for (gi = 0; gi < PIN_W; gi++) begin : g_sync
        always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
                sync_a[gi]    <= PIN_IDLE[gi];
                sync_b[gi]    <= PIN_IDLE[gi];
                sync_prev[gi] <= PIN_IDLE[gi];
            end else begin
                sync_a[gi]    <= pins[gi];
                sync_b[gi]    <= sync_a[gi];
                sync_prev[gi] <= sync_b[gi];
            end
        end
    end

    pin_bundle_t pin_now;
    pin_bundle_t pin_old;
    assign pin_now = pin_bundle_t'(sync_b);
    assign pin_old = pin_bundle_t'(sync_prev);

    // register storage
    core_state_t state;
    logic [12:0] pc;
    logic [7:0]  status;
    logic [1:0]  power_flags;
    vref_ctrl_t  vref_control;
    logic [7:0]  interrupt_control;
    logic        periph_comp_flag;
    logic        periph_comp_enable;
    logic [3:0]  comparator_mode;
    logic [7:0]  timer_options;
    logic [4:0]  port_a_direction;
    logic [7:0]  port_b_direction;
    logic [4:0]  pc_high_latch;
    logic [7:0]  timer_count;
    logic [7:0]  indirect_pointer;
    logic [4:0]  port_a_pins;
    logic [7:0]  port_b_pins;
    logic [7:0]  working_accumulator;
    logic        wdt_enable;
    logic [31:0] watchdog_counter;
    logic [5:0]  event_status;
    logic [5:0]  event_mask;

    // apb decode; writes land on the edge that samples pready high
    logic [7:0] idx;
    logic       bus_write;
    logic [7:0] wdata;
    assign idx       = paddr[9:2];
    assign wdata     = pwdata[7:0];
    assign bus_write = psel && penable && pready && pwrite && is_mapped(idx)
                       && (paddr[1:0] == 2'b00);

    function automatic logic wr(input logic [7:0] sel, input logic [7:0] at, input logic en);
        wr = en && (sel == at);
    endfunction

    // cause decode, strongest first: a collapsing supply beats all else
    logic asleep;
    logic pf_ev;
    logic bor_ev;
    logic ext_ev;
    logic wdt_to;
    logic wdt_rst_ev;
    logic wdt_wake_ev;
    logic irq_pending;
    logic irq_wake_ev;
    logic any_reset;
    logic wake_ev;
    logic sleep_cmd;
    logic clrwdt_cmd;

    assign asleep = (state == ST_ASLEEP);
    assign pf_ev  = pin_now.power_fail && !pin_old.power_fail;
    assign bor_ev = pin_now.brownout_detect && !pin_old.brownout_detect && !pf_ev;
    assign ext_ev = !pin_now.external_reset_pin_n && pin_old.external_reset_pin_n
                    && !pf_ev && !bor_ev;
    assign wdt_to = wdt_enable && (watchdog_counter == WDT_CYCLES - 1);
    assign wdt_rst_ev  = wdt_to && !asleep && !pf_ev && !bor_ev && !ext_ev;
    assign wdt_wake_ev = wdt_to && asleep && !pf_ev && !bor_ev && !ext_ev;
    assign any_reset   = pf_ev || bor_ev || ext_ev || wdt_rst_ev;
    // wake needs the source enabled, whatever the global enable says
    assign irq_pending = (interrupt_control[4] && interrupt_control[1])
                       || (interrupt_control[3] && interrupt_control[0])
                       || (interrupt_control[5] && interrupt_control[2])
                       || (periph_comp_enable && periph_comp_flag);
    assign irq_wake_ev = asleep && irq_pending && !any_reset && !wdt_wake_ev;
    assign wake_ev     = wdt_wake_ev || irq_wake_ev;
    assign sleep_cmd   = wr(idx, `IDX_CORE_CONTROL, bus_write) && wdata[0] && (state == ST_RUN);
    assign clrwdt_cmd  = wr(idx, `IDX_CORE_CONTROL, bus_write) && wdata[1];

    // core state and program counter
    always_ff @(posedge sys_clk) begin
        if (sys_rst || any_reset) begin
            state <= ST_RUN;
            pc    <= 13'h0000;
        end else begin
            case (state)
                ST_RUN: begin
                    if (sleep_cmd) begin
                        state <= ST_ASLEEP;
                    end else if (wr(idx, `IDX_PC_LOW, bus_write)) begin
                        pc <= {pc_high_latch, wdata};
                    end
                end
                ST_ASLEEP: begin
                    if (wdt_wake_ev) begin
                        state <= ST_RUN;
                        pc    <= pc + 13'h0001;
                    end else if (irq_wake_ev) begin
                        pc <= pc + 13'h0001;
                        state <= interrupt_control[`BIT_GLOBAL_IRQ_ENABLE] ? ST_WAKE : ST_RUN;
                    end
                end
                ST_WAKE: begin
                    state <= ST_VECTOR;
                end
                ST_VECTOR: begin
                    state <= ST_RUN;
                    pc    <= `IRQ_VECTOR;
                end
                default: begin
                    state <= ST_RUN;
                end
            endcase
        end
    end

    // status: bits 4,3 are hardware owned, the rest software writable
    always_ff @(posedge sys_clk) begin
        if (sys_rst || pf_ev) begin
            // power-on status, unknown low bits read zero
            status <= `RST_STATUS_POR;
        end else if (bor_ev) begin
            // unknown 4..3 kept as they were
            status <= {3'b000, status[4:0]};
        end else if (ext_ev && asleep) begin
            status <= {5'b00010, status[2:0]};
        end else if (ext_ev) begin
            status <= {3'b000, status[4:0]};
        end else if (wdt_rst_ev) begin
            status <= {4'b0000, status[3:0]};
        end else if (wdt_wake_ev) begin
            status <= {status[7:5], 2'b00, status[2:0]};
        end else if (irq_wake_ev) begin
            status <= {status[7:5], 2'b10, status[2:0]};
        end else if (sleep_cmd) begin
            status[`BIT_TIMEOUT]   <= 1'b1;
            status[`BIT_POWERDOWN] <= 1'b0;
        end else if (clrwdt_cmd) begin
            status[`BIT_TIMEOUT]   <= 1'b1;
            status[`BIT_POWERDOWN] <= 1'b1;
        end else if (wr(idx, `IDX_STATUS, bus_write)) begin
            status <= {wdata[7:5], status[4:3], wdata[2:0]};
        end
    end

    // power flags: software sets them so the next reset can be told apart
    always_ff @(posedge sys_clk) begin
        if (sys_rst || pf_ev) begin
            power_flags <= 2'b00;
        end else if (bor_ev) begin
            power_flags[`BIT_FLAG_BROWNOUT] <= 1'b0;
        end else if (wr(idx, `IDX_POWER_FLAGS, bus_write)) begin
            power_flags <= wdata[1:0];
        end
    end

    // vref control cleared on any reset, unused bit stays zero
    always_ff @(posedge sys_clk) begin
        if (sys_rst || any_reset) begin
            vref_control <= vref_ctrl_t'(`RST_ZERO);
        end else if (wr(idx, `IDX_VREF_CONTROL, bus_write)) begin
            vref_control <= vref_ctrl_t'(wdata & `MASK_VREF);
        end
    end

    // interrupt flags: a pin event in the write cycle still sets its flag
    always_ff @(posedge sys_clk) begin
        if (sys_rst || pf_ev) begin
            interrupt_control <= `RST_ZERO;
            periph_comp_flag  <= 1'b0;
        end else if (any_reset) begin
            interrupt_control <= {7'h00, interrupt_control[0]};
            periph_comp_flag  <= 1'b0;
        end else begin
            if (wr(idx, `IDX_INT_CONTROL, bus_write)) begin
                interrupt_control <= wdata;
            end
            if (wr(idx, `IDX_PERIPH_FLAGS, bus_write)) begin
                periph_comp_flag <= wdata[`BIT_PERIPH_COMP];
            end
            if (pin_now.int_pin && !pin_old.int_pin) begin
                interrupt_control[1] <= 1'b1;
            end
            if (pin_now.port_change && !pin_old.port_change) begin
                interrupt_control[0] <= 1'b1;
            end
            if (pin_now.comparator_change && !pin_old.comparator_change) begin
                periph_comp_flag <= 1'b1;
            end
        end
    end

    // registers that every reset loads and every wake keeps
    always_ff @(posedge sys_clk) begin
        if (sys_rst || any_reset) begin
            comparator_mode    <= 4'h0;
            periph_comp_enable <= 1'b0;
            pc_high_latch      <= 5'h00;
            timer_options      <= `RST_OPTIONS;
            port_a_direction   <= 5'(`RST_PORT_A_DIR);
            port_b_direction   <= `RST_PORT_B_DIR;
        end else if (bus_write) begin
            case (idx)
                `IDX_COMPARATOR:     comparator_mode    <= wdata[3:0];
                `IDX_PERIPH_ENABLES: periph_comp_enable <= wdata[`BIT_PERIPH_COMP];
                `IDX_PC_HIGH_LATCH:  pc_high_latch      <= wdata[4:0];
                `IDX_TIMER_OPTIONS:  timer_options      <= wdata;
                `IDX_PORT_A_DIR:     port_a_direction   <= wdata[4:0];
                `IDX_PORT_B_DIR:     port_b_direction   <= wdata;
                default: begin
                end
            endcase
        end
    end

    // plain storage: unknown at power-on, kept by every other cause
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            timer_count         <= `RST_ZERO;
            indirect_pointer    <= `RST_ZERO;
            port_a_pins         <= 5'h00;
            port_b_pins         <= `RST_ZERO;
            working_accumulator <= `RST_ZERO;
        end else if (bus_write) begin
            case (idx)
                `IDX_TIMER_COUNT:      timer_count         <= wdata;
                `IDX_INDIRECT_POINTER: indirect_pointer    <= wdata;
                `IDX_PORT_A:           port_a_pins         <= wdata[4:0];
                `IDX_PORT_B:           port_b_pins         <= wdata;
                `IDX_ACCUMULATOR:      working_accumulator <= wdata;
                default: begin
                end
            endcase
        end
    end

    // watchdog; the timeout itself restarts the count
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wdt_enable <= 1'b1;
        end else if (wr(idx, `IDX_CORE_CONTROL, bus_write)) begin
            wdt_enable <= wdata[2];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst || any_reset || wake_ev || sleep_cmd || clrwdt_cmd || wdt_to
            || !wdt_enable) begin
            watchdog_counter <= 32'h0000_0000;
        end else begin
            watchdog_counter <= watchdog_counter + 32'h0000_0001;
        end
    end

    // sticky event status, write one to clear; a new event wins the clear
    logic [5:0] event_set;
    assign event_set = {irq_wake_ev, wdt_wake_ev, wdt_rst_ev, ext_ev, bor_ev, pf_ev};

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            event_status <= 6'h00;
            event_mask   <= 6'h00;
        end else begin
            if (wr(idx, `IDX_EVENT_STATUS, bus_write)) begin
                event_status <= (event_status & ~wdata[5:0]) | event_set;
            end else begin
                event_status <= event_status | event_set;
            end
            if (wr(idx, `IDX_EVENT_MASK, bus_write)) begin
                event_mask <= wdata[5:0];
            end
        end
    end

    // read mux; unimplemented bits come back as zero
    logic [7:0] read_value;
    always_comb begin
        read_value = 8'h00;
        case (idx)
            `IDX_TIMER_COUNT:      read_value = timer_count;
            `IDX_PC_LOW:           read_value = pc[7:0];
            `IDX_STATUS:           read_value = status;
            `IDX_INDIRECT_POINTER: read_value = indirect_pointer;
            `IDX_PORT_A:           read_value = {3'b000, port_a_pins};
            `IDX_PORT_B:           read_value = port_b_pins;
            `IDX_PC_HIGH_LATCH:    read_value = {3'b000, pc_high_latch};
            `IDX_INT_CONTROL:      read_value = interrupt_control;
            `IDX_PERIPH_FLAGS:     read_value = {1'b0, periph_comp_flag, 6'h00};
            `IDX_COMPARATOR:       read_value = {pin_now.comparator_two_result,
                                                 pin_now.comparator_one_result,
                                                 2'b00, comparator_mode};
            `IDX_TIMER_OPTIONS:    read_value = timer_options;
            `IDX_PORT_A_DIR:       read_value = {3'b000, port_a_direction};
            `IDX_PORT_B_DIR:       read_value = port_b_direction;
            `IDX_PERIPH_ENABLES:   read_value = {1'b0, periph_comp_enable, 6'h00};
            `IDX_POWER_FLAGS:      read_value = {6'h00, power_flags};
            `IDX_VREF_CONTROL:     read_value = 8'(vref_control);
            `IDX_ACCUMULATOR:      read_value = working_accumulator;
            `IDX_CORE_CONTROL:     read_value = {2'b00, state, 1'b0, wdt_enable, 1'b0,
                                                 asleep};
            `IDX_EVENT_STATUS:     read_value = {2'b00, event_status};
            `IDX_EVENT_MASK:       read_value = {2'b00, event_mask};
            default:               read_value = 8'h00;
        endcase
    end

    // apb slave: one wait state, answer registered so outputs stay glitch free
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (psel && penable && !pready) begin
            pready  <= 1'b1;
            pslverr <= !is_mapped(idx) || (paddr[1:0] != 2'b00);
            prdata  <= (pwrite || !is_mapped(idx) || (paddr[1:0] != 2'b00))
                       ? 32'h0000_0000 : {24'h00_0000, read_value};
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // registered outputs
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            irq         <= 1'b0;
            vref_out    <= vref_ctrl_t'(`RST_ZERO);
            core_asleep <= 1'b0;
        end else begin
            irq         <= |(event_status & event_mask);
            vref_out    <= vref_control;
            core_asleep <= asleep;
        end
    end

endmodule

/* tb/reset_wakeup_monitor.sv */
// port-level checker for the reset/wake register block
`timescale 1ns/1ps
module reset_wakeup_monitor
    import reset_wakeup_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [9:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire pin_bundle_t pins,
    input wire logic        irq,
    input wire vref_ctrl_t  vref_out,
    input wire logic        core_asleep
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // bus phases as seen at the edges
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable && !pready;
    endsequence
    a_one_wait_state: assert property (setup_s ##1 access_s |=> pready)
        else $error("answer not one cycle after access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("ready outside an access");
    a_err_zero_data: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("refused access returned data");
    a_unaligned_err: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr)
        else $error("unaligned access not refused");
    a_vref_gap_zero: assert property (vref_out.unused == 1'b0)
        else $error("unused reference bit set");
    a_reset_clears: assert property (disable iff (1'b0) sys_rst |=>
        vref_out == 8'h00 && !irq && !core_asleep && !pready)
        else $error("outputs not cleared by reset");
    a_brownout_vref: assert property ($rose(pins.brownout_detect) |->
        ##[2:6] vref_out == 8'h00)
        else $error("brown-out left reference enabled");
    a_pin_wakes: assert property ($fell(pins.external_reset_pin_n) && core_asleep |->
        ##[2:6] !core_asleep)
        else $error("pin reset did not leave sleep");
endmodule
bind reset_wakeup_register_init reset_wakeup_monitor reset_wakeup_monitor_i (
    .sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pins, .irq, .vref_out, .core_asleep);

/* tb/reset_wakeup_register_init_bench.sv */
// self-checking bench: reset causes and wake-ups seen through apb reads
`timescale 1ns/1ps
`include "reset_wakeup_map.svh"
module reset_wakeup_register_init_bench;
    import reset_wakeup_pkg::*;
    localparam int WDT = 64; // short watchdog so time-outs fit the run
    logic        sys_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [9:0]  paddr = 10'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, irq, core_asleep, er;
    pin_bundle_t pins = 8'h04; // reset pin idles high
    vref_ctrl_t  vref_out;
    int          error_cnt = 0, checks = 0, cyc = 0, k;
    logic [15:0] por_tab [12] = '{16'h0200, 16'h0318, 16'h0a00, 16'h0b00, 16'h0c00, 16'h1f00,
        16'h81ff, 16'h851f, 16'h86ff, 16'h8c00, 16'h8e00, 16'h9f00};
    logic [15:0] set_tab [9] = '{16'h8100, 16'h8500, 16'h8600, 16'h1f0f, 16'h0a01, 16'h8c40,
        16'ha320, 16'h0b08, 16'h0210};
    reset_wakeup_register_init #(.WDT_CYCLES(WDT)) reset_wakeup_register_init_i (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pins(pins), .irq(irq), .vref_out(vref_out), .core_asleep(core_asleep));
    always #20 sys_clk = ~sys_clk;
    // hang guard: twenty thousand cycles is ample for the sequence
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            end_of_test();
        end
    end
    task end_of_test;
        $display("checks=%0d errors=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task waitc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // one apb transfer; held until ready is sampled, one idle edge after
    task xfer(input logic w, input logic [9:0] a, input logic [31:0] d);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge sys_clk) penable <= 1'b1;
        // no wait count assumed: the loop ends on ready, else the hang guard ends it
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task wr(input logic [7:0] i, input logic [7:0] d);
        xfer(1'b1, {i, 2'b00}, {24'h0, d});
    endtask
    task rc(input logic [7:0] i, input logic [7:0] e);
        xfer(1'b0, {i, 2'b00}, 32'h0);
        cmp({er, rd[30:0]}, {24'h0, e});
    endtask
    // toggle a pin and back, then keep the watchdog off after any reset
    task pulse(input int b);
        pins[b] <= ~pins[b];
        waitc(6);
        pins[b] <= ~pins[b];
        waitc(6);
        wr(`IDX_CORE_CONTROL, 8'h00);
    endtask
    initial begin
        waitc(12);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        wr(`IDX_CORE_CONTROL, 8'h00);
        wr(`IDX_EVENT_STATUS, 8'h3f);
        for (k = 0; k < 12; k++) rc(por_tab[k][15:8], por_tab[k][7:0]);
        xfer(1'b0, 10'h01c, 32'h0); cmp({31'h0, er}, 32'h1);
        xfer(1'b1, 10'h27d, 32'hff); cmp({31'h0, er}, 32'h1);
        wr(`IDX_VREF_CONTROL, 8'hff); rc(`IDX_VREF_CONTROL, 8'hef);
        cmp({24'h0, vref_out}, 32'hef);
        for (k = 0; k < 9; k++) wr(set_tab[k][15:8], set_tab[k][7:0]);
        wr(`IDX_CORE_CONTROL, 8'h01); waitc(2); cmp({31'h0, core_asleep}, 32'h1);
        pulse(4); rc(`IDX_PC_LOW, 8'h11); rc(`IDX_STATUS, 8'h10);
        rc(`IDX_INT_CONTROL, 8'h09); rc(`IDX_EVENT_STATUS, 8'h20);
        cmp({31'h0, irq}, 32'h1); wr(`IDX_EVENT_MASK, 8'h00); waitc(2); cmp({31'h0, irq}, 32'h0);
        wr(`IDX_EVENT_STATUS, 8'h20); rc(`IDX_EVENT_STATUS, 8'h00);
        for (k = 0; k < 6; k++) rc(set_tab[k][15:8], set_tab[k][7:0]);
        pins[7:6] <= 2'b11; waitc(3); rc(`IDX_COMPARATOR, 8'hcf);
        pins[7:6] <= 2'b00;
        rc(`IDX_VREF_CONTROL, 8'hef);
        wr(`IDX_INT_CONTROL, 8'h00); wr(`IDX_CORE_CONTROL, 8'h01); pulse(5);
        rc(`IDX_PERIPH_FLAGS, 8'h40); rc(`IDX_PC_LOW, 8'h12);
        wr(`IDX_PERIPH_FLAGS, 8'h00); wr(`IDX_INT_CONTROL, 8'h88);
        wr(`IDX_CORE_CONTROL, 8'h01); pulse(4); rc(`IDX_PC_LOW, 8'h04);
        // pin reset while asleep
        // flags of the vectored wake are cleared, else sleep ends at once
        wr(`IDX_INT_CONTROL, 8'h00);
        wr(`IDX_POWER_FLAGS, 8'h03); wr(`IDX_STATUS, 8'he7); wr(`IDX_CORE_CONTROL, 8'h01);
        waitc(1); cmp({31'h0, core_asleep}, 32'h1);
        pulse(2); rc(`IDX_STATUS, 8'h17); rc(`IDX_POWER_FLAGS, 8'h03);
        for (k = 0; k < 12; k++)
            if (k != 1 && k != 3 && k != 10) rc(por_tab[k][15:8], por_tab[k][7:0]);
        // pin reset while running
        // clear-watchdog sets bits 4,3, so the running result differs from sleep
        wr(`IDX_STATUS, 8'he7); wr(`IDX_CORE_CONTROL, 8'h02);
        pulse(2); rc(`IDX_STATUS, 8'h1f);
        // brown-out clears flag bit 0 only
        wr(`IDX_STATUS, 8'he7); wr(`IDX_VREF_CONTROL, 8'ha6); pulse(1);
        rc(`IDX_POWER_FLAGS, 8'h02); rc(`IDX_STATUS, 8'h1f); rc(`IDX_VREF_CONTROL, 8'h00);
        // watchdog reset in run, then time-out wake in sleep
        wr(`IDX_STATUS, 8'he7); wr(`IDX_CORE_CONTROL, 8'h04); waitc(WDT + 20);
        wr(`IDX_CORE_CONTROL, 8'h00); rc(`IDX_STATUS, 8'h0f); rc(`IDX_PC_LOW, 8'h00);
        wr(`IDX_STATUS, 8'he7); wr(`IDX_CORE_CONTROL, 8'h05); waitc(WDT + 20);
        wr(`IDX_CORE_CONTROL, 8'h00); rc(`IDX_STATUS, 8'he7); rc(`IDX_PC_LOW, 8'h01);
        pulse(0); rc(`IDX_STATUS, 8'h18); rc(`IDX_POWER_FLAGS, 8'h00);
        end_of_test();
    end
endmodule
